// ### hw/tssync_cfg.svh
/*
 * Constants of the timer slave-sync and burst block: register offsets,
 * field positions, mode codes, reset values and timing counts.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef TSSYNC_CFG_SVH
`define TSSYNC_CFG_SVH

// Register word offsets (byte addresses, one aligned word each)
`define TSS_OFF_CTRL1      8'h00
`define TSS_OFF_CTRL2      8'h04
`define TSS_OFF_SMODE      8'h08
`define TSS_OFF_IER        8'h0c
`define TSS_OFF_STATUS     8'h10
`define TSS_OFF_CHCFG      8'h18
`define TSS_OFF_POL        8'h20
`define TSS_OFF_CNT        8'h24
`define TSS_OFF_PSC        8'h28
`define TSS_OFF_ARR        8'h2c
`define TSS_OFF_CMP1       8'h34
`define TSS_OFF_BDTR       8'h44
`define TSS_OFF_BCTRL      8'h48
`define TSS_OFF_BWIN       8'h4c
`define TSS_OFF_DEBUG      8'h50
// Slave mode codes
`define TSS_SMS_RESET      4'h4
`define TSS_SMS_GATED      4'h5
`define TSS_SMS_TRIG       4'h6
`define TSS_SMS_RSTTRIG    4'h8
// Trigger select codes
`define TSS_TS_CH1         5'h05
`define TSS_TS_CH2         5'h06
// Channel select code that maps the channel onto its own input
`define TSS_CHSEL_OWN      2'h1
// Field positions
`define TSS_CTRL1_CEN      0
`define TSS_CTRL1_URS      2
`define TSS_IER_UIE        0
`define TSS_IER_TIE        6
`define TSS_IER_UDE        8
`define TSS_IER_TDE        14
`define TSS_ST_UIF         0
`define TSS_ST_TIF         6
`define TSS_POL_CH1P       1
`define TSS_POL_CH1NP      3
`define TSS_POL_CH2P       5
`define TSS_POL_CH2NP      7
`define TSS_BDTR_IDLE_OFFSTATE_SEL      10
`define TSS_BDTR_MOE       15
// Reset values
`define TSS_ARR_RESET      16'hffff
// Resynchroniser depth on the trigger input (flip-flop stages)
`define TSS_SYNC_STAGES    2
`endif

// ### hw/tssync_pkg.sv
/*
 * Types shared by the timer slave-sync and burst block.
 * Assumes the cfg header is on the include path.
 */
package tssync_pkg;
    // Register port request from software or the DMA side
    typedef struct packed {
        logic [7:0]  addr;   // Byte address
        logic [15:0] wdata;  // Write data
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
    } tss_req_s;

    // Burst engine states, Gray coded along idle -> request -> wait
    typedef enum logic [1:0] {
        TSS_B_IDLE = 2'b00,
        TSS_B_REQ  = 2'b01,
        TSS_B_WAIT = 2'b11
    } tss_burst_e;
endpackage

// ### hw/tssync_core.sv
/*
 * Slave-mode synchronisation controller of a general purpose timer with
 * a small counter core, the DMA burst engine and debug freeze of the
 * outputs. One clock, synchronous active-low reset.
 * Assumes channel inputs are asynchronous pins and the DMA controller
 * answers each request by one access to the burst window register.
 */
// Implementation choices: the placing of the registers and the plain strobed port.
//
// What this block does
// - Reset mode edge clears counter and prescaler
// - Reset trigger with source-select low updates preloads
// - Reset trigger restarts counting upward from zero
// - Trigger sets flag, raises enabled irq/dma
// - Gated mode counts only while input active
// - Gated mode never runs with enable bit clear
// - Gated mode flags both start and stop
// - Trigger mode edge starts counter, sets flag
// - Select 00101 picks channel 1, 00110 channel 2
// - Polarity bits pick rising or low/falling
// - Trigger input resynchronised, fixed short delay
// - Combined mode edge resets, updates, starts counter
// - Event launches DMA burst through window register
// - Five-bit length sets transfers per burst
// - Five-bit base is offset from control 1
// - Burst accesses walk consecutive registers
// - Debug halt freezes counter if freeze bit set
// - Frozen counter disables outputs like enable cleared
// - Idle off-state selects inactive drive or release
// - Combined mode selected by code 1000
// - Trigger mode sets enable bit by hardware
`timescale 1ns/1ns
`default_nettype none
`include "tssync_cfg.svh"

module tssync_core #(
    parameter int CNT_W = 16                // Counter width
) (
    // Clock and reset
    input  wire logic                  CLOCK,
    input  wire logic                  RESETN,
    // Register port
    input  wire tssync_pkg::tss_req_s  REQ,
    output logic [15:0]                RDATA,
    // Channel pins and debug
    input  wire logic                  CH1_PIN,
    input  wire logic                  CH2_PIN,
    input  wire logic                  DEBUG_HALT,
    input  wire logic                  DEBUG_FREEZE_BIT,
    // DMA and interrupt requests
    output logic                       BURST_DMA_REQ,
    output logic                       TRIG_DMA_REQ,
    output logic                       TRIG_IRQ,
    // Output stage
    output logic                       OC1_OUT,
    output logic                       OC1_OE
);
    // Software registers
    logic [15:0]      ctrl1_reg;            // Counter enable, update source
    logic [15:0]      smode_reg;            // Trigger select, slave mode
    logic [15:0]      ier_reg;              // Interrupt/DMA enables
    logic [15:0]      status_reg;           // Sticky flags
    logic [1:0]       chsel_reg;            // Channel 1 select
    logic [15:0]      pol_reg;              // Channel polarity bits
    logic [CNT_W-1:0] cnt_reg;              // Counter
    logic [15:0]      psc_reg;              // Prescaler preload
    logic [15:0]      psc_act_reg;          // Active prescaler
    logic [15:0]      psc_cnt_reg;          // Prescaler counter
    logic [CNT_W-1:0] arr_reg;              // Auto-reload preload
    logic [CNT_W-1:0] arr_act_reg;          // Active auto-reload
    logic [CNT_W-1:0] cmp_reg;              // Compare preload
    logic [CNT_W-1:0] cmp_act_reg;          // Active compare
    logic [15:0]      bdtr_reg;             // Main output enable, off-state
    logic [15:0]      bctrl_reg;            // Burst base and length
    logic [4:0]       bidx_reg;             // Burst transfer index
    tssync_pkg::tss_burst_e bstate_reg;     // Burst engine state

    // Field views
    logic [3:0] slave_mode_sel;                        // Slave mode code
    logic [4:0] tsel;                       // Trigger select code
    logic [4:0] blen;                       // Burst length minus one
    logic [4:0] bbase;                      // Burst base offset
    assign slave_mode_sel   = {smode_reg[15], smode_reg[2:0]};
    assign tsel  = smode_reg[8:4];
    assign bbase = bctrl_reg[4:0];
    assign blen  = bctrl_reg[12:8];

    // Resynchronisers on the pins; first stage read only by the second
    logic [`TSS_SYNC_STAGES-1:0] ch1_sync;  // Channel 1 chain
    logic [`TSS_SYNC_STAGES-1:0] ch2_sync;  // Channel 2 chain
    logic                        trg_prev;  // Trigger level one cycle ago

    // Two flops per pin before any logic reads them
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            ch1_sync <= '0;
            ch2_sync <= '0;
        end else begin
            ch1_sync <= {ch1_sync[0], CH1_PIN};
            ch2_sync <= {ch2_sync[0], CH2_PIN};
        end
    end

    // Trigger routing and polarity; TSS_POL_CH1P set to 1 inverts to active-low
    logic ch1_filt;                         // Channel 1 after polarity
    logic ch2_filt;                         // Channel 2 after polarity
    logic trg_lvl;                          // Selected trigger, active high
    logic trg_edge;                         // Active edge pulse
    always_comb begin
        ch1_filt = (chsel_reg == `TSS_CHSEL_OWN) &&
                   (ch1_sync[1] ^ pol_reg[`TSS_POL_CH1P]);
        ch2_filt = ch2_sync[1] ^ pol_reg[`TSS_POL_CH2P];
        case (tsel)
            `TSS_TS_CH1: trg_lvl = ch1_filt;
            `TSS_TS_CH2: trg_lvl = ch2_filt;
            default:     trg_lvl = 1'b0;    // Other sources not wired here
        endcase
    end
    assign trg_edge = trg_lvl && !trg_prev;

    // Remember the trigger level for edge and gate-change detection
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            trg_prev <= 1'b0;
        end else begin
            trg_prev <= trg_lvl;
        end
    end

    // Slave mode decode
    logic is_reset;                         // Reset mode
    logic is_gated;                         // Gated mode
    logic is_trig;                          // Trigger mode
    logic is_rt;                            // Combined reset + trigger
    logic slave_rst;                        // Counter reinit request
    logic slave_evt;                        // Trigger flag event
    logic frozen;                           // Debug freeze in force
    logic run;                              // Counter may advance
    assign is_reset  = (slave_mode_sel == `TSS_SMS_RESET);
    assign is_gated  = (slave_mode_sel == `TSS_SMS_GATED);
    assign is_trig   = (slave_mode_sel == `TSS_SMS_TRIG);
    assign is_rt     = (slave_mode_sel == `TSS_SMS_RSTTRIG);
    assign slave_rst = trg_edge && (is_reset || is_rt);
    // Gated mode flags the counter starting and stopping
    assign slave_evt = is_gated ? ((trg_lvl != trg_prev) && ctrl1_reg[`TSS_CTRL1_CEN])
                                : (trg_edge && (is_reset || is_trig || is_rt));
    assign frozen    = DEBUG_HALT && DEBUG_FREEZE_BIT;
    // Gate needs both the enable bit and the active level
    assign run = ctrl1_reg[`TSS_CTRL1_CEN] && !frozen &&
                 (!is_gated || trg_lvl);

    // Prescaler tick and overflow
    logic psc_tick;                         // Counter advance enable
    logic ovf;                              // Counter overflow
    logic upd_evt;                          // Update event (reload)
    logic upd_flag;                         // Update flag source
    logic sw_cnt_wr;                        // Software counter write
    logic bus_wr;                           // Effective write strobe
    logic [7:0]  wr_addr;                   // Effective write address
    logic [15:0] wr_data;                   // Effective write data
    assign psc_tick = run && (psc_cnt_reg == psc_act_reg);
    assign ovf      = psc_tick && (cnt_reg == arr_act_reg);
    // Slave reinit updates only when source-select is low
    assign upd_evt  = ovf || (slave_rst && !ctrl1_reg[`TSS_CTRL1_URS]);
    assign upd_flag = upd_evt;

    // Burst window redirect: a window access becomes an access to base+index
    logic        win_hit;                   // Access hits the window
    logic [7:0]  win_addr;                  // Redirected register address
    assign win_hit  = (REQ.wr || REQ.rd) && (REQ.addr == `TSS_OFF_BWIN);
    assign win_addr = {1'b0, 5'(bbase + bidx_reg), 2'b00};
    assign bus_wr   = REQ.wr;
    assign wr_addr  = win_hit ? win_addr : REQ.addr;
    assign wr_data  = REQ.wdata;
    assign sw_cnt_wr = bus_wr && (wr_addr == `TSS_OFF_CNT);

    // Prescaler counter; cleared on slave reinit with the counter
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            psc_cnt_reg <= '0;
        end else if (slave_rst) begin
            psc_cnt_reg <= '0;
        end else if (psc_tick) begin
            psc_cnt_reg <= '0;
        end else if (run) begin
            psc_cnt_reg <= psc_cnt_reg + 16'h0001;
        end
    end

    // Counter: slave reinit wins over counting and software writes
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            cnt_reg <= '0;
        end else if (slave_rst) begin
            cnt_reg <= '0;
        end else if (sw_cnt_wr) begin
            cnt_reg <= wr_data[CNT_W-1:0];
        end else if (ovf) begin
            cnt_reg <= '0;
        end else if (psc_tick) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    // Shadow registers load from preloads on update
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            arr_act_reg <= CNT_W'(`TSS_ARR_RESET);
            cmp_act_reg <= '0;
            psc_act_reg <= '0;
        end else if (upd_evt) begin
            arr_act_reg <= arr_reg;
            cmp_act_reg <= cmp_reg;
            psc_act_reg <= psc_reg;
        end
    end

    // Control 1: trigger and combined modes set the enable bit themselves
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            ctrl1_reg <= '0;
        end else begin
            if (bus_wr && wr_addr == `TSS_OFF_CTRL1) begin
                ctrl1_reg <= wr_data;
            end
            if (trg_edge && (is_trig || is_rt)) begin
                ctrl1_reg[`TSS_CTRL1_CEN] <= 1'b1;
            end
        end
    end

    // Plain software registers; reserved slots absorb writes silently
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            smode_reg <= '0;
            ier_reg   <= '0;
            chsel_reg <= '0;
            pol_reg   <= '0;
            psc_reg   <= '0;
            arr_reg   <= CNT_W'(`TSS_ARR_RESET);
            cmp_reg   <= '0;
            bdtr_reg  <= '0;
            bctrl_reg <= '0;
        end else if (bus_wr) begin
            case (wr_addr)
                `TSS_OFF_SMODE: smode_reg <= wr_data;
                `TSS_OFF_IER:   ier_reg   <= wr_data;
                `TSS_OFF_CHCFG: chsel_reg <= wr_data[1:0];
                `TSS_OFF_POL:   pol_reg   <= wr_data;
                `TSS_OFF_PSC:   psc_reg   <= wr_data;
                `TSS_OFF_ARR:   arr_reg   <= wr_data[CNT_W-1:0];
                `TSS_OFF_CMP1:  cmp_reg   <= wr_data[CNT_W-1:0];
                `TSS_OFF_BDTR:  bdtr_reg  <= wr_data;
                `TSS_OFF_BCTRL: bctrl_reg <= wr_data;
                default:        ;           // Reserved: no effect
            endcase
        end
    end

    // Status: hardware set wins over software clear (write 0 clears)
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            status_reg <= '0;
        end else begin
            if (bus_wr && wr_addr == `TSS_OFF_STATUS) begin
                status_reg <= status_reg & wr_data;
            end
            if (slave_evt) begin
                status_reg[`TSS_ST_TIF] <= 1'b1;
            end
            if (upd_flag) begin
                status_reg[`TSS_ST_UIF] <= 1'b1;
            end
        end
    end

    // Burst engine: update event launches length+1 window transfers
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            bstate_reg <= tssync_pkg::TSS_B_IDLE;
            bidx_reg   <= '0;
        end else begin
            case (bstate_reg)
                tssync_pkg::TSS_B_IDLE: begin
                    if (upd_evt && ier_reg[`TSS_IER_UDE]) begin
                        bidx_reg   <= '0;
                        bstate_reg <= tssync_pkg::TSS_B_REQ;
                    end
                end
                tssync_pkg::TSS_B_REQ: begin
                    bstate_reg <= tssync_pkg::TSS_B_WAIT;
                end
                tssync_pkg::TSS_B_WAIT: begin
                    if (win_hit) begin
                        if (bidx_reg == blen) begin
                            bstate_reg <= tssync_pkg::TSS_B_IDLE;
                        end else begin
                            bidx_reg   <= bidx_reg + 5'h01;
                            bstate_reg <= tssync_pkg::TSS_B_REQ;
                        end
                    end
                end
                default: bstate_reg <= tssync_pkg::TSS_B_IDLE;
            endcase
        end
    end

    // Request outputs, all registered
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            BURST_DMA_REQ <= 1'b0;
            TRIG_DMA_REQ  <= 1'b0;
            TRIG_IRQ      <= 1'b0;
        end else begin
            BURST_DMA_REQ <= (bstate_reg == tssync_pkg::TSS_B_REQ);
            TRIG_DMA_REQ  <= slave_evt && ier_reg[`TSS_IER_TDE];
            TRIG_IRQ      <= (status_reg[`TSS_ST_TIF] && ier_reg[`TSS_IER_TIE]) ||
                             (status_reg[`TSS_ST_UIF] && ier_reg[`TSS_IER_UIE]);
        end
    end

    // Output stage: freeze acts as main enable cleared
    logic moe_eff;                          // Main enable after debug
    assign moe_eff = bdtr_reg[`TSS_BDTR_MOE] && !frozen;
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            OC1_OUT <= 1'b0;
            OC1_OE  <= 1'b0;
        end else if (moe_eff) begin
            OC1_OUT <= (cnt_reg >= cmp_act_reg);
            OC1_OE  <= 1'b1;
        end else begin
            OC1_OUT <= 1'b0;                // Inactive level
            OC1_OE  <= bdtr_reg[`TSS_BDTR_IDLE_OFFSTATE_SEL]; // Else released
        end
    end

    // Read data, valid the cycle after the strobe
    logic [7:0] rd_addr;                    // Effective read address
    assign rd_addr = win_hit ? win_addr : REQ.addr;
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            RDATA <= '0;
        end else if (REQ.rd) begin
            case (rd_addr)
                `TSS_OFF_CTRL1:  RDATA <= ctrl1_reg;
                `TSS_OFF_SMODE:  RDATA <= smode_reg;
                `TSS_OFF_IER:    RDATA <= ier_reg;
                `TSS_OFF_STATUS: RDATA <= status_reg;
                `TSS_OFF_CHCFG:  RDATA <= {14'h0000, chsel_reg};
                `TSS_OFF_POL:    RDATA <= pol_reg;
                `TSS_OFF_CNT:    RDATA <= 16'(cnt_reg);
                `TSS_OFF_PSC:    RDATA <= psc_reg;
                `TSS_OFF_ARR:    RDATA <= 16'(arr_reg);
                `TSS_OFF_CMP1:   RDATA <= 16'(cmp_reg);
                `TSS_OFF_BDTR:   RDATA <= bdtr_reg;
                `TSS_OFF_BCTRL:  RDATA <= bctrl_reg;
                `TSS_OFF_DEBUG:  RDATA <= {14'h0000, frozen, DEBUG_HALT};
                default:         RDATA <= '0;
            endcase
        end else begin
            RDATA <= '0;
        end
    end

    // Checks
    sequence s_edge_rst;
        trg_edge && (is_reset || is_rt);
    endsequence
    a_reset_clears_cnt: assert property (@(posedge CLOCK) disable iff (!RESETN)
        s_edge_rst |=> cnt_reg == '0) else $error("counter not cleared");
    a_reset_update: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (s_edge_rst and !ctrl1_reg[`TSS_CTRL1_URS]) |=> arr_act_reg == $past(arr_reg))
        else $error("no reload on reset trigger");
    a_gate_holds: assert property (@(posedge CLOCK) disable iff (!RESETN)
        is_gated && !trg_lvl && !sw_cnt_wr && !slave_rst |=> $stable(cnt_reg))
        else $error("gated counter moved");
    a_gate_cen_low: assert property (@(posedge CLOCK) disable iff (!RESETN)
        !ctrl1_reg[`TSS_CTRL1_CEN] && !sw_cnt_wr && !slave_rst |=> $stable(cnt_reg))
        else $error("counter ran with enable clear");
    a_trig_sets_cen: assert property (@(posedge CLOCK) disable iff (!RESETN)
        trg_edge && is_trig |=> ctrl1_reg[`TSS_CTRL1_CEN] && status_reg[`TSS_ST_TIF])
        else $error("trigger mode did not start");
    a_trig_dma_req: assert property (@(posedge CLOCK) disable iff (!RESETN)
        slave_evt && ier_reg[`TSS_IER_TDE] |=> TRIG_DMA_REQ)
        else $error("trigger dma missing");
    a_burst_index: assert property (@(posedge CLOCK) disable iff (!RESETN)
        bstate_reg == tssync_pkg::TSS_B_WAIT && win_hit && bidx_reg != blen
        |=> bidx_reg == $past(bidx_reg) + 5'h01) else $error("burst index stuck");
    a_freeze_outputs: assert property (@(posedge CLOCK) disable iff (!RESETN)
        frozen |=> !OC1_OUT && OC1_OE == $past(bdtr_reg[`TSS_BDTR_IDLE_OFFSTATE_SEL]))
        else $error("outputs live while frozen");
endmodule
`default_nettype wire

// ### verification/tssync_dma_model.sv
/* DMA partner: answers each burst request with one window write.
   Assumes the bench muxes this request onto the register port. */
`timescale 1ns/1ns
`default_nettype none
module tssync_dma_model (
    // Clock and reset
    input  wire logic                CLOCK,
    input  wire logic                RESETN,
    // Burst handshake
    input  wire logic                BURST_DMA_REQ,
    output var tssync_pkg::tss_req_s REQ_OUT
);
    logic odd_reg; // Second slot of each burst
    // One write the cycle after each pulse; data wanders when idle
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            REQ_OUT <= '0;
            odd_reg <= 1'b0;
        end else begin
            REQ_OUT.wr   <= BURST_DMA_REQ;
            REQ_OUT.rd   <= 1'b0;
            REQ_OUT.addr <= 8'h4c;
            if (BURST_DMA_REQ) begin
                odd_reg       <= ~odd_reg;
                // Reserved slot only ever gets zero
                REQ_OUT.wdata <= odd_reg ? 16'h0000 : 16'h0123;
            end else begin
                REQ_OUT.wdata <= ~REQ_OUT.wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/test_timer_slave_sync_dma_burst.sv
/* Self-checking bench of the slave-sync and burst block.
   Assumes the DMA model owns the port while it writes. */
`timescale 1ns/1ns
`default_nettype none
module test_timer_slave_sync_dma_burst;
    logic                 clock = 1'b0;  // 10 MHz
    logic                 resetn = 1'b0; // Sync reset
    tssync_pkg::tss_req_s tb_req = '0;   // Bench requests
    tssync_pkg::tss_req_s dma_req;       // Model requests
    tssync_pkg::tss_req_s req;           // Merged port
    logic [15:0]          rdata, v, d;
    logic                 ch1 = 1'b0, ch2 = 1'b0, halt = 1'b0, frz = 1'b0;
    logic                 bdma, tdma, irq, oc_out, oc_oe;
    int                   n_fail = 0, total_checks = 0, n_burst = 0, n_tdma = 0;
    always #50 clock = ~clock; // Rate never changes while triggers arrive
    // Model wins the port only while it writes
    assign req = (dma_req.wr === 1'b1) ? dma_req : tb_req;
    tssync_core u_tssync_core (.CLOCK(clock), .RESETN(resetn), .REQ(req),
        .RDATA(rdata), .CH1_PIN(ch1), .CH2_PIN(ch2), .DEBUG_HALT(halt),
        .DEBUG_FREEZE_BIT(frz), .BURST_DMA_REQ(bdma), .TRIG_DMA_REQ(tdma),
        .TRIG_IRQ(irq), .OC1_OUT(oc_out), .OC1_OE(oc_oe));
    tssync_dma_model u_tssync_dma_model (.CLOCK(clock), .RESETN(resetn),
        .BURST_DMA_REQ(bdma), .REQ_OUT(dma_req));
    // Pulse counters
    always @(posedge clock) begin
        if (bdma === 1'b1) n_burst++;
        if (tdma === 1'b1) n_tdma++;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] dt);
        @(posedge clock) tb_req <= '{addr: a, wdata: dt, wr: 1'b1, rd: 1'b0};
        @(posedge clock) tb_req.wr <= 1'b0;
    endtask
    // Data stand in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [15:0] q);
        @(posedge clock) tb_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock) tb_req.rd <= 1'b0;
        @(posedge clock) q = rdata;
    endtask
    // Counter advance over a fixed span
    task delta(output logic [15:0] dd);
        logic [15:0] a, b;
        rd(8'h24, a);
        repeat (20) @(posedge clock);
        rd(8'h24, b);
        dd = b - a;
    endtask
    task t_reset_burst;
        wr(8'h18, 16'h0001); // Own input
        wr(8'h20, 16'h0000); // Rising edges
        wr(8'h48, 16'h010b); // Base 0x0b, two transfers
        wr(8'h0c, 16'h4141);
        wr(8'h08, 16'h0054); // Reset mode on channel 1
        wr(8'h00, 16'h0001);
        repeat (40) @(posedge clock);
        @(posedge clock) ch1 <= 1'b1;
        repeat (12) @(posedge clock);
        rd(8'h24, v); chk(v < 16'h0010, 1'b1);
        chk(irq, 1'b1);
        chk(n_tdma, 16'd1);
        chk(n_burst, 16'd2);
        rd(8'h2c, v); chk(v, 16'h0123);
        rd(8'h30, v); chk(v, 16'h0000);
        wr(8'h0c, 16'h0000);
        $display("reset and burst done");
    endtask
    task t_gated;
        wr(8'h00, 16'h0000);
        wr(8'h20, 16'h0002); // Active low
        wr(8'h08, 16'h0055);
        @(posedge clock) ch1 <= 1'b0;
        delta(d); chk(d, 16'h0000);
        @(posedge clock) ch1 <= 1'b1;
        wr(8'h00, 16'h0001);
        wr(8'h10, 16'h0000);
        @(posedge clock) ch1 <= 1'b0;
        delta(d); chk(d != 16'h0000, 1'b1);
        rd(8'h10, v); chk(v[6], 1'b1);
        wr(8'h10, 16'h0000);
        @(posedge clock) ch1 <= 1'b1;
        repeat (5) @(posedge clock);
        delta(d); chk(d, 16'h0000);
        rd(8'h10, v); chk(v[6], 1'b1);
        $display("gated done");
    endtask
    task t_trig;
        wr(8'h00, 16'h0000);
        wr(8'h08, 16'h0066); // Trigger mode on channel 2
        wr(8'h10, 16'h0000);
        @(posedge clock) ch2 <= 1'b1;
        repeat (6) @(posedge clock);
        rd(8'h00, v); chk(v[0], 1'b1);
        rd(8'h10, v); chk(v[6], 1'b1);
        delta(d); chk(d != 16'h0000, 1'b1);
        $display("trigger done");
    endtask
    task t_combined;
        wr(8'h00, 16'h0000);
        @(posedge clock) ch1 <= 1'b0;
        wr(8'h20, 16'h0000);
        wr(8'h08, 16'h8050); // Combined mode
        wr(8'h10, 16'h0000);
        @(posedge clock) ch1 <= 1'b1;
        repeat (6) @(posedge clock);
        rd(8'h24, v); chk(v < 16'h0010, 1'b1);
        rd(8'h10, v); chk(v[0], 1'b1);
        rd(8'h00, v); chk(v[0], 1'b1);
        $display("combined done");
    endtask
    task t_debug;
        wr(8'h44, 16'h8000);
        @(posedge clock) {halt, frz} <= 2'b11;
        repeat (4) @(posedge clock);
        chk(oc_oe, 1'b0);
        delta(d); chk(d, 16'h0000);
        wr(8'h44, 16'h8400);
        repeat (3) @(posedge clock);
        chk({oc_oe, oc_out}, 2'b10);
        @(posedge clock) frz <= 1'b0;
        delta(d); chk(d != 16'h0000, 1'b1);
        chk({oc_oe, oc_out}, 2'b11);
        $display("debug done");
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        t_reset_burst();
        t_gated();
        t_trig();
        t_combined();
        t_debug();
        final_report();
    end
    // Watchdog, about thirty times the expected run
    initial begin
        #1000000;
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
